// ===== verilog/dsam_pkg.sv
/*
 * Shared constants and carrier types of the diagnostic status and alarm monitor.
 * Assumes 16-bit register words reached through 16-bit serial frames with a
 * six-bit byte address in bits 13:8 of the command word.
 */
package dsam_pkg;

    // Serial frame layout.
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [3:0] FRAME_FIRST = 4'h0;
    localparam int CMD_WR_BIT = 15;
    localparam int ADDR_HI = 13;
    localparam int ADDR_LO = 8;

    // Byte addresses of the even (low) byte of each register word.
    localparam logic [5:0] ADDR_FLASH_WRITE_COUNTER = 6'h00;
    localparam logic [5:0] ADDR_THR_ONE = 6'h26;
    localparam logic [5:0] ADDR_THR_TWO = 6'h28;
    localparam logic [5:0] ADDR_WIN_ONE = 6'h2A;
    localparam logic [5:0] ADDR_WIN_TWO = 6'h2C;
    localparam logic [5:0] ADDR_ALM_CFG = 6'h2E;
    localparam logic [5:0] ADDR_MISC = 6'h34;
    localparam logic [5:0] ADDR_FAULT = 6'h3C;

    // Reset value of every writable register.
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field positions of the fault flag word.
    localparam int FF_ZST = 15;
    localparam int FF_YST = 14;
    localparam int FF_XST = 13;
    localparam int FF_GST = 10;
    localparam int FF_ALM_TWO = 9;
    localparam int FF_ALM_ONE = 8;
    localparam int FF_CHKSUM = 6;
    localparam int FF_STDIAG = 5;
    localparam int FF_OVR = 4;
    localparam int FF_SPI = 3;
    localparam int FF_FLUPD = 2;
    localparam int FF_SUP_HI = 1;
    localparam int FF_SUP_LO = 0;

    // Field positions of the alarm configuration, threshold and misc words.
    localparam int AC_SRC_TWO_LO = 12;
    localparam int AC_SRC_ONE_LO = 8;
    localparam int AC_ROC_TWO = 7;
    localparam int AC_ROC_ONE = 6;
    localparam int AC_FILT = 4;
    localparam int AC_OUT_EN = 2;
    localparam int AC_OUT_POL = 1;
    localparam int AC_OUT_LINE = 0;
    localparam int TH_POL = 15;
    localparam int TH_VAL_HI = 13;
    localparam int MISC_MEMTEST = 11;

    // Alarm trigger source codes.
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_SUPPLY = 4'h1;
    localparam logic [3:0] SRC_GYRO = 4'h2;
    localparam logic [3:0] SRC_XACC = 4'h5;
    localparam logic [3:0] SRC_YACC = 4'h6;
    localparam logic [3:0] SRC_ZACC = 4'h7;
    localparam logic [3:0] SRC_TEMP = 4'h8;
    localparam logic [3:0] SRC_PITCH = 4'h9;
    localparam logic [3:0] SRC_ROLL = 4'hA;
    localparam logic [3:0] SRC_AUX = 4'hB;

    // Rate-of-change window counts below this stand for one sample.
    localparam logic [7:0] WIN_MIN = 8'h01;

    // One 14-bit word of every alarm source.
    typedef struct packed {
        logic [13:0] supply;
        logic [13:0] gyro;
        logic [13:0] xacc;
        logic [13:0] yacc;
        logic [13:0] zacc;
        logic [13:0] temp;
        logic [13:0] pitch;
        logic [13:0] roll;
        logic [13:0] aux;
    } dsam_src_t;

    // Error conditions reported by the sensor core, as levels.
    typedef struct packed {
        logic zst_fail;
        logic yst_fail;
        logic xst_fail;
        logic gyro_st_fail;
        logic st_diag_fail;
        logic overrange;
        logic flash_upd_fail;
        logic supply_high;
        logic supply_low;
    } dsam_cond_t;

    // Checksum test sequencer states.
    typedef enum logic [1:0] {
        CHK_IDLE = 2'b01,
        CHK_RUN = 2'b10
    } dsam_chk_t;

endpackage

// ===== verilog/dsam_top.sv
/*
 * Diagnostic status and dual alarm monitor with its 16-bit serial register port.
 * Assumes sample_tick is a one-cycle pulse per sample from the core, the sensor
 * and condition inputs are on clk, and SCLK runs well below a third of clk.
 */
// What this block does
// R1 - Count every write into the nonvolatile flash memory.
// R2 - Memory-test bit starts a flash checksum check; host waits 20 ms for result.
// R3 - Each read of the fault flag word clears all its flags.
// R4 - A still present condition sets its flag again next sample cycle.
// R5 - Both supply flags clear by themselves when supply returns to range.
// R6 - Bits 15, 14, 13 and 10 flag accelerometer and gyroscope self-test failures.
// R7 - Bits 9 and 8 show whether alarm two and alarm one are active.
// R8 - Bits 6, 5, 4, 2 flag checksum, self-test, overrange and flash update failure.
// R9 - Bit 3 flags a transfer whose SCLK count is not a multiple of 16.
// R10 - Bit 1 flags supply above 5.25 V, bit 0 supply below 4.75 V.
// R11 - Two alarms with own source, mode, threshold and count; shared filter and output.
// R12 - Threshold bit 15 picks greater-than when 1, less-than when 0.
// R13 - Threshold bits 13 to 0 hold the value in the source format.
// R14 - Window bits 7 to 0 give sample count; 0 and 1 both mean one.
// R15 - Rate-of-change period is the sample count times the sample period.
// R16 - Config bits 15:12 choose alarm two source; unused codes disable.
// R17 - Config bits 11:8 choose alarm one source with the same codes.
// R18 - Config bits 7 and 6 choose rate-of-change or static mode per alarm.
// R19 - Config bit 4 compares filtered data when 1, unfiltered when 0.
// R20 - Config bit 2 enables the indicator; bit 1 sets its active level.
// R21 - Config bit 0 routes the indicator to line 2 when 1, line 1 when 0.
// R22 - Pitch and roll sources always compare filtered data.
// R23 - Alarms are evaluated once per sample; indicator follows either active alarm.
`timescale 1ns/1ps

module dsam_top
    import dsam_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Serial register port pins.
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_din,
    output logic spi_dout,
    // Sensor core side.
    input wire logic sample_tick,
    input wire dsam_src_t raw_data,
    input wire dsam_src_t filt_data,
    input wire dsam_cond_t cond,
    input wire logic flash_write_event,
    // Flash checksum engine.
    output logic flash_check_start,
    input wire logic flash_check_done,
    input wire logic flash_check_fail,
    // Alarm indicator lines.
    output logic digital_line_1_out,
    output logic digital_line_1_oe,
    output logic digital_line_2_out,
    output logic digital_line_2_oe
);

    // Replaces one byte of a register word.
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction
    // Picks a source word; bit 14 of the result says the code is a legal source.
    function automatic logic [14:0] pick_src(input dsam_src_t s, input logic [3:0] code);
        case (code)
            SRC_SUPPLY: pick_src = {1'b1, s.supply};
            SRC_GYRO: pick_src = {1'b1, s.gyro};
            SRC_XACC: pick_src = {1'b1, s.xacc};
            SRC_YACC: pick_src = {1'b1, s.yacc};
            SRC_ZACC: pick_src = {1'b1, s.zacc};
            SRC_TEMP: pick_src = {1'b1, s.temp};
            SRC_PITCH: pick_src = {1'b1, s.pitch};
            SRC_ROLL: pick_src = {1'b1, s.roll};
            SRC_AUX: pick_src = {1'b1, s.aux};
            default: pick_src = 15'h0000;
        endcase
    endfunction
    // Signed compare of a 15-bit value against a 14-bit threshold word.
    function automatic logic hit(input logic [14:0] x, input logic [15:0] thr);
        logic signed [14:0] xs;
        logic signed [14:0] ts;
        xs = x;
        ts = {thr[TH_VAL_HI], thr[TH_VAL_HI:0]};
        hit = thr[TH_POL] ? (xs > ts) : (xs < ts);
    endfunction
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] din_s;
    logic [3:0] bit_cnt_r;
    logic [14:0] rx_r;
    logic [15:0] tx_r;
    logic spi_dout_r;
    logic [15:0] thr_r [2];
    logic [15:0] win_r [2];
    logic [15:0] cfg_r;
    logic [15:0] flash_write_counter_r;
    logic [15:0] fault_r;
    logic [1:0] alarm_r;
    dsam_chk_t chk_r;
    logic chk_start_r;
    logic line1_out_r;
    logic line1_oe_r;
    logic line2_out_r;
    logic line2_oe_r;
    // Pin synchronisers; stage 0 feeds only stage 1.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sclk_s <= 3'h7;
            cs_s <= 3'h7;
            din_s <= 2'h0;
        end
        else
        begin
            sclk_s <= {sclk_s[1:0], spi_sclk};
            cs_s <= {cs_s[1:0], spi_cs_n};
            din_s <= {din_s[0], spi_din};
        end
    end

    // Edge and frame decode of the serial port.
    wire cs_active = ~cs_s[1];
    wire sclk_rise = sclk_s[1] & ~sclk_s[2] & cs_active;
    wire sclk_fall = ~sclk_s[1] & sclk_s[2] & cs_active;
    wire cs_end = cs_s[1] & ~cs_s[2];
    wire frame_done = sclk_rise & (bit_cnt_r == FRAME_LAST);
    wire [15:0] frame_word = {rx_r, din_s[1]};
    wire wr_cmd = frame_done & frame_word[CMD_WR_BIT];
    wire rd_cmd = frame_done & ~frame_word[CMD_WR_BIT];
    wire [5:0] frame_addr = frame_word[ADDR_HI:ADDR_LO];
    wire [5:0] word_addr = {frame_addr[5:1], 1'b0};
    wire byte_hi = frame_addr[0];
    wire [7:0] frame_byte = frame_word[7:0];
    wire spi_err_evt = cs_end & (bit_cnt_r != FRAME_FIRST); // R9

    // Bit counter and receive shifter; counter wraps every 16 edges.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bit_cnt_r <= FRAME_FIRST;
            rx_r <= 15'h0000;
        end
        else if (cs_end)
        begin
            bit_cnt_r <= FRAME_FIRST;
        end
        else if (sclk_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            rx_r <= {rx_r[13:0], din_s[1]};
        end
    end
    // Register write strobes and the fault word read strobe.
    wire wr_thr_one = wr_cmd & (word_addr == ADDR_THR_ONE);
    wire wr_thr_two = wr_cmd & (word_addr == ADDR_THR_TWO);
    wire wr_win_one = wr_cmd & (word_addr == ADDR_WIN_ONE);
    wire wr_win_two = wr_cmd & (word_addr == ADDR_WIN_TWO);
    wire wr_cfg = wr_cmd & (word_addr == ADDR_ALM_CFG);
    wire wr_misc = wr_cmd & (word_addr == ADDR_MISC);
    wire memtest_req = wr_misc & byte_hi & frame_byte[MISC_MEMTEST - 8];
    wire fault_rd = rd_cmd & (word_addr == ADDR_FAULT);
    // Read data; unused bits of each word except the alarm config word, and unmapped addresses, read zero.
    wire chk_busy = (chk_r == CHK_RUN);
    wire [15:0] misc_rd = {4'h0, chk_busy, 11'h000};
    wire [15:0] win_one_rd = {8'h00, win_r[0][7:0]};
    wire [15:0] win_two_rd = {8'h00, win_r[1][7:0]};
    wire [15:0] thr_one_rd = {thr_r[0][TH_POL], 1'b0, thr_r[0][TH_VAL_HI:0]};
    wire [15:0] thr_two_rd = {thr_r[1][TH_POL], 1'b0, thr_r[1][TH_VAL_HI:0]};
    wire [15:0] rd_data =
        (word_addr == ADDR_FAULT) ? fault_r :
        (word_addr == ADDR_FLASH_WRITE_COUNTER) ? flash_write_counter_r :
        (word_addr == ADDR_ALM_CFG) ? cfg_r :
        (word_addr == ADDR_THR_ONE) ? thr_one_rd :
        (word_addr == ADDR_THR_TWO) ? thr_two_rd :
        (word_addr == ADDR_WIN_ONE) ? win_one_rd :
        (word_addr == ADDR_WIN_TWO) ? win_two_rd :
        (word_addr == ADDR_MISC) ? misc_rd : 16'h0000;

    // Transmit shifter: loaded at the end of a read frame, shifted on falling SCLK.
    always_ff @(posedge clk)
    begin
        if (srst)
            {tx_r, spi_dout_r} <= 17'h0;
        else if (frame_done)
        begin
            tx_r <= rd_cmd ? rd_data : 16'h0000;
        end
        else if (sclk_fall)
        begin
            spi_dout_r <= tx_r[15];
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    // Writable alarm registers, byte at a time.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            thr_r <= '{2{REG_RESET}};
            win_r <= '{2{REG_RESET}};
            cfg_r <= REG_RESET;
        end
        else
        begin
            if (wr_thr_one)
                thr_r[0] <= put_byte(thr_r[0], byte_hi, frame_byte); // R13
            if (wr_thr_two)
                thr_r[1] <= put_byte(thr_r[1], byte_hi, frame_byte); // R13
            if (wr_win_one)
                win_r[0] <= put_byte(win_r[0], byte_hi, frame_byte); // R14
            if (wr_win_two)
                win_r[1] <= put_byte(win_r[1], byte_hi, frame_byte); // R14
            if (wr_cfg)
                cfg_r <= put_byte(cfg_r, byte_hi, frame_byte);
        end
    end
    // Flash write counter, read only.
    always_ff @(posedge clk)
    begin
        if (srst)
            flash_write_counter_r <= REG_RESET;
        else if (flash_write_event)
            flash_write_counter_r <= flash_write_counter_r + 16'h0001; // R1
    end
    // Checksum sequencer; the memory-test bit reads 1 until the engine reports done.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            chk_r <= CHK_IDLE;
            chk_start_r <= 1'b0;
        end
        else
        begin
            chk_start_r <= 1'b0;
            case (chk_r)
                CHK_IDLE:
                begin
                    if (memtest_req)
                    begin
                        chk_r <= CHK_RUN; // R2
                        chk_start_r <= 1'b1;
                    end
                end
                CHK_RUN:
                    if (flash_check_done)
                        chk_r <= CHK_IDLE;
                default: chk_r <= CHK_IDLE;
            endcase
        end
    end
    wire chk_fail_evt = chk_busy & flash_check_done & flash_check_fail;
    // Alarm channels; channel 0 is alarm one, channel 1 is alarm two.
    wire [3:0] src_code [2];
    wire roc_mode [2];
    assign src_code[0] = cfg_r[AC_SRC_ONE_LO +: 4]; // R17
    assign src_code[1] = cfg_r[AC_SRC_TWO_LO +: 4]; // R16
    assign roc_mode[0] = cfg_r[AC_ROC_ONE]; // R18
    assign roc_mode[1] = cfg_r[AC_ROC_TWO]; // R18

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_alarm
        logic [7:0] cnt_r;
        logic [13:0] snap_r;
        wire incline = (src_code[ch] == SRC_PITCH) | (src_code[ch] == SRC_ROLL);
        wire use_filt = cfg_r[AC_FILT] | incline; // R19 R22
        wire [14:0] pick = pick_src(use_filt ? filt_data : raw_data, src_code[ch]); // R11
        wire src_ok = pick[14]; // R16
        wire [13:0] value = pick[13:0];
        wire [7:0] win = (win_r[ch][7:0] < WIN_MIN) ? WIN_MIN : win_r[ch][7:0]; // R14
        wire period_end = (cnt_r + 8'h01) >= win; // R15
        wire [14:0] value_x = {value[13], value};
        wire [14:0] delta = value_x - {snap_r[13], snap_r};
        wire static_hit = hit(value_x, thr_r[ch]); // R12
        wire roc_hit = hit(delta, thr_r[ch]); // R12

        // Window counter, snapshot and alarm advance once per sample; a static alarm
        // follows every sample, a rate-of-change alarm on a legal source changes only at a window end.
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                {cnt_r, snap_r} <= 22'h0;
                alarm_r[ch] <= 1'b0;
            end
            else if (sample_tick)
            begin
                cnt_r <= period_end ? 8'h00 : cnt_r + 8'h01; // R15
                if (period_end)
                    snap_r <= value;
                if (!src_ok)
                    alarm_r[ch] <= 1'b0;
                else if (!roc_mode[ch])
                    alarm_r[ch] <= static_hit; // R23
                else if (period_end)
                    alarm_r[ch] <= roc_hit; // R18
            end
        end
    end

    // Fault flag sources; every set is sampled once per sample except the events.
    wire [15:0] flag_set;
    assign flag_set[FF_ZST] = sample_tick & cond.zst_fail; // R6
    assign flag_set[FF_YST] = sample_tick & cond.yst_fail; // R6
    assign flag_set[FF_XST] = sample_tick & cond.xst_fail; // R6
    assign flag_set[12:11] = 2'h0;
    assign flag_set[FF_GST] = sample_tick & cond.gyro_st_fail; // R6
    assign flag_set[FF_ALM_TWO] = sample_tick & alarm_r[1]; // R7
    assign flag_set[FF_ALM_ONE] = sample_tick & alarm_r[0]; // R7
    assign flag_set[7] = 1'b0;
    assign flag_set[FF_CHKSUM] = chk_fail_evt; // R8
    assign flag_set[FF_STDIAG] = sample_tick & cond.st_diag_fail; // R8
    assign flag_set[FF_OVR] = sample_tick & cond.overrange; // R8
    assign flag_set[FF_SPI] = spi_err_evt; // R9
    assign flag_set[FF_FLUPD] = sample_tick & cond.flash_upd_fail; // R8
    assign flag_set[FF_SUP_HI] = sample_tick & cond.supply_high; // R10
    assign flag_set[FF_SUP_LO] = sample_tick & cond.supply_low; // R10
    // Clears: a status read clears all, supply flags also clear when back in range.
    wire [1:0] sup_ok = {~cond.supply_high, ~cond.supply_low};
    wire [15:0] flag_clr = {16{fault_rd}} | {14'h0000, {2{sample_tick}} & sup_ok}; // R3 R5
    // Fault flag word; a set in the cycle of a clear wins.
    always_ff @(posedge clk)
    begin
        if (srst)
            fault_r <= REG_RESET;
        else
            fault_r <= (fault_r & ~flag_clr) | flag_set; // R4
    end

    // Indicator drive: enable, polarity and line choice are shared by both alarms.
    wire ind_en = cfg_r[AC_OUT_EN]; // R20
    wire ind_act = |alarm_r; // R23
    wire ind_lvl = cfg_r[AC_OUT_POL] ? ind_act : ~ind_act; // R20
    wire on_line2 = cfg_r[AC_OUT_LINE]; // R21

    // Registered indicator pins; a line not driven shows zero.
    always_ff @(posedge clk)
    begin
        if (srst)
            {line1_out_r, line1_oe_r, line2_out_r, line2_oe_r} <= 4'h0;
        else
        begin
            line1_oe_r <= ind_en & ~on_line2; // R21
            line1_out_r <= ind_en & ~on_line2 & ind_lvl;
            line2_oe_r <= ind_en & on_line2; // R21
            line2_out_r <= ind_en & on_line2 & ind_lvl;
        end
    end
    // Output assignments from flip-flops.
    assign spi_dout = spi_dout_r;
    assign flash_check_start = chk_start_r;
    assign digital_line_1_out = line1_out_r;
    assign digital_line_1_oe = line1_oe_r;
    assign digital_line_2_out = line2_out_r;
    assign digital_line_2_oe = line2_oe_r;

endmodule // dsam_top

// ===== dv/dsam_host_model.sv
/* Host model that drives serial frames into the monitor.
   Assumes mode 3 pins and a clk far faster than SCLK. */
`timescale 1ns/1ps
module dsam_host_model (
    // Clock.
    input wire logic clk,
    // Serial pins.
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_din,
    input wire logic spi_dout
);
    // Pins idle with the select released and SCLK high.
    initial
    begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_din = 1'b1;
    end
    // Sends n bits MSB first, four clk per SCLK level so the synchroniser keeps up.
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk) spi_cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i > 15 - n; i--)
        begin
            spi_sclk <= 1'b0;
            spi_din <= tx[i];
            repeat (4) @(posedge clk);
            spi_sclk <= 1'b1;
            rx = {rx[14:0], spi_dout};
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        spi_cs_n <= 1'b1;
        spi_din <= ~spi_din; // A released line does not keep its last value.
        repeat (8) @(posedge clk);
    endtask
endmodule // dsam_host_model

// ===== dv/dsam_top_sva.sv
/* Port checker of the monitor.
   Assumes it is bound to dsam_top and sees only its pins. */
`timescale 1ns/1ps
module dsam_top_sva
    import dsam_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Watched pins.
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_dout,
    input wire logic sample_tick,
    input wire logic flash_check_start,
    input wire logic digital_line_1_out,
    input wire logic digital_line_1_oe,
    input wire logic digital_line_2_out,
    input wire logic digital_line_2_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Checksum start, indicator drive and serial output relations.
    property p_chk_pulse;
        flash_check_start |=> !flash_check_start;
    endproperty
    a_chk_pulse: assert property (p_chk_pulse) else $error("start pulse too long");
    property p_chk_cause;
        flash_check_start |-> $past(spi_cs_n, 6) == 1'b0;
    endproperty
    a_chk_cause: assert property (p_chk_cause) else $error("start without a frame");
    property p_quiet1;
        !digital_line_1_oe |-> !digital_line_1_out;
    endproperty
    a_quiet1: assert property (p_quiet1) else $error("line 1 driven while off");
    property p_quiet2;
        !digital_line_2_oe |-> !digital_line_2_out;
    endproperty
    a_quiet2: assert property (p_quiet2) else $error("line 2 driven while off");
    property p_one_line;
        !(digital_line_1_oe && digital_line_2_oe);
    endproperty
    a_one_line: assert property (p_one_line) else $error("both lines enabled");
    property p_ind_cause;
        $changed(digital_line_1_out) || $changed(digital_line_2_out) |->
            $past(sample_tick, 2) || $past(sample_tick, 3) || !$past(spi_cs_n, 4);
    endproperty
    a_ind_cause: assert property (p_ind_cause) else $error("indicator moved unprompted");
    property p_rst_idle;
        $fell(srst) |-> !spi_dout && !digital_line_1_oe && !digital_line_2_oe;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
    property p_dout_edge;
        $changed(spi_dout) |->
            !$past(spi_sclk, 2) || !$past(spi_sclk, 3) || !$past(spi_sclk, 4);
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("dout moved off SCLK fall");
    // Main scenarios reached.
    c_chk: cover property (flash_check_start);
    c_line2: cover property (digital_line_2_oe && digital_line_2_out);
    c_line1: cover property (digital_line_1_oe && digital_line_1_out);
endmodule // dsam_top_sva

// ===== dv/dsam_top_bench.sv
/* Self-checking bench of the monitor.
   Assumes the host model and the checker are compiled with it. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dsam_top_bench
    import dsam_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, cs_n, din, dout, cstart, o1, e1, o2, e2;
    logic tick = 1'b0, fwe = 1'b0, cdone = 1'b0, cfail = 1'b0;
    dsam_src_t raw = '0, filt = '0;
    dsam_cond_t cond = '0;
    int errors = 0, n_tests = 0, n_start = 0;
    logic [15:0] rd;
    // Clock and start counter.
    always #50 clk = ~clk;
    always @(posedge clk) if (cstart === 1'b1) n_start++;
    dsam_top dsam_top_inst (.clk(clk), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_din(din), .spi_dout(dout), .sample_tick(tick), .raw_data(raw),
        .filt_data(filt), .cond(cond), .flash_write_event(fwe),
        .flash_check_start(cstart), .flash_check_done(cdone), .flash_check_fail(cfail),
        .digital_line_1_out(o1), .digital_line_1_oe(e1), .digital_line_2_out(o2),
        .digital_line_2_oe(e2));
    dsam_host_model dsam_host_model_inst (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_din(din), .spi_dout(dout));
    // Bus access, sample step and end-of-test tasks.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] x;
        dsam_host_model_inst.xfer({2'b10, a, d}, 16, x);
    endtask
    task automatic wr16(input logic [5:0] a, input logic [15:0] w);
        wr(a | 6'h01, w[15:8]);
        wr(a, w[7:0]);
    endtask
    task automatic chk_reg(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] x;
        dsam_host_model_inst.xfer({2'b00, a, 8'h00}, 16, x);
        dsam_host_model_inst.xfer(16'h0000, 16, rd);
        `CHK(rd, e)
    endtask
    task automatic step;
        @(posedge clk) tick <= 1'b1;
        @(posedge clk) tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic stop_test;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Test sequence.
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        wr16(ADDR_THR_ONE, 16'h8341);
        wr16(ADDR_THR_TWO, 16'hFFFF);
        wr16(ADDR_WIN_ONE, 16'hFF12);
        wr(6'h10, 8'h5A);
        wr(ADDR_FAULT, 8'hFF);
        chk_reg(ADDR_THR_ONE, 16'h8341);
        chk_reg(ADDR_THR_TWO, 16'hBFFF);
        chk_reg(ADDR_WIN_ONE, 16'h0012);
        chk_reg(6'h10, 16'h0000);
        chk_reg(ADDR_FAULT, 16'h0000);
        cond <= '1;
        step();
        chk_reg(ADDR_FAULT, 16'hE437);
        chk_reg(ADDR_FAULT, 16'h0000);
        step();
        cond <= '0;
        step();
        chk_reg(ADDR_FAULT, 16'hE434);
        dsam_host_model_inst.xfer(16'h0000, 8, rd);
        chk_reg(ADDR_FAULT, 16'h0008);
        repeat (3)
        begin
            @(posedge clk) fwe <= 1'b1;
            @(posedge clk) fwe <= 1'b0;
        end
        chk_reg(ADDR_FLASH_WRITE_COUNTER, 16'h0003);
        wr(ADDR_MISC | 6'h01, 8'h08);
        chk_reg(ADDR_MISC, 16'h0800);
        `CHK(n_start, 1)
        @(posedge clk) {cdone, cfail} <= 2'b11;
        @(posedge clk) {cdone, cfail} <= 2'b00;
        chk_reg(ADDR_MISC, 16'h0000);
        chk_reg(ADDR_FAULT, 16'h0040);
        wr16(ADDR_THR_TWO, 16'h3CBF);
        filt.xacc <= 14'h0400;
        raw.xacc <= 14'h3000;
        wr16(ADDR_ALM_CFG, 16'h5517);
        step();
        step();
        chk_reg(ADDR_FAULT, 16'h0100);
        `CHK({e1, o1, e2, o2}, 4'b0011)
        wr(ADDR_ALM_CFG, 8'h15);
        `CHK({e1, o1, e2, o2}, 4'b0010)
        wr(ADDR_ALM_CFG, 8'h16);
        `CHK({e1, o1, e2, o2}, 4'b1100)
        wr(ADDR_ALM_CFG, 8'h10);
        `CHK({e1, o1, e2, o2}, 4'b0000)
        filt.xacc <= 14'h3000;
        step();
        step();
        chk_reg(ADDR_FAULT, 16'h0300);
        step();
        chk_reg(ADDR_FAULT, 16'h0200);
        filt.pitch <= 14'h0400;
        wr16(ADDR_ALM_CFG, 16'h0906);
        step();
        step();
        `CHK(o1, 1'b1)
        wr(ADDR_ALM_CFG | 6'h01, 8'h03);
        step();
        step();
        `CHK(o1, 1'b0)
        // Rate-of-change alarm one on unfiltered data over a one-sample window.
        raw.xacc <= 14'h0000;
        wr(ADDR_WIN_ONE, 8'h00);
        wr16(ADDR_ALM_CFG, 16'h0540);
        step();
        step();
        dsam_host_model_inst.xfer({2'b00, ADDR_FAULT, 8'h00}, 16, rd);
        raw.xacc <= 14'h0400;
        step();
        step();
        chk_reg(ADDR_FAULT, 16'h0100);
        step();
        step();
        chk_reg(ADDR_FAULT, 16'h0000);
        stop_test();
    end
    // Cuts a hang short after about 30000 clocks.
    initial
    begin
        #3000000;
        errors++;
        stop_test();
    end
endmodule // dsam_top_bench
bind dsam_top dsam_top_sva dsam_top_sva_inst (.clk(clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_dout(spi_dout), .sample_tick(sample_tick),
    .flash_check_start(flash_check_start), .digital_line_1_out(digital_line_1_out),
    .digital_line_1_oe(digital_line_1_oe), .digital_line_2_out(digital_line_2_out),
    .digital_line_2_oe(digital_line_2_oe));
